// *** logic/dpc_loop_config.sv ***
// Module: configuration registers and decode for the main and auxiliary loops
// What this block does
// - Phase-measure bit 1 disables auxiliary loop; its detector measures selected-input phase.
// - Second multiplier fed from auxiliary loop when source bit 0, main loop when 1.
// - Main rate to second multiplier: 00 12xE1, 01 16xE1, 10 24xDS1.
// - Main rate codes 000 and 001 give 77.76 MHz, digital or analog feedback.
// - Auxiliary bandwidth code 00 18 Hz, 01 35 Hz, 10 70 Hz, 11 unused.
// - Main acquisition bandwidth code 11 18 Hz, 00 35 Hz, 01 70 Hz.
// - Damping codes 001..011 fixed; 100 and 101 depend on bandwidth.
// - Low-frequency analog gain used only with automatic gain selection enabled.
// - Auxiliary gain enable 0 leaves detector unused; 1 picks gain by locking mode.
// - High-frequency analog gain used for analog lock above 8 kHz when enabled.
// - Digital gain used in digital feedback and whenever auto gain is off.
`default_nettype none
module dpc_loop_config (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_hit,
	input wire logic main_phase_locked,
	input wire dpc_pkg::dpc_lock_t aux_lock_mode,
	input wire logic main_auto_gain_en,
	output dpc_pkg::dpc_cfg_t cfg
);
	import dpc_pkg::*;

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	logic [7:0] main_rate_r;
	logic [7:0] aux_bw_r;
	logic [7:0] main_locked_bw_r;
	logic [7:0] main_acq_bw_r;
	logic [7:0] aux_damp_r;
	logic [7:0] main_damp_r;
	logic [7:0] aux_gain_r;
	logic [7:0] rdata_nxt;
	logic hit_nxt;
	dpc_cfg_t cfg_r;
	dpc_cfg_t cfg_nxt;

	function automatic logic [7:0] masked(input logic [7:0] wd, input logic [7:0] msk, input logic [7:0] rv);
		masked = (wd & msk) | (rv & ~msk);
	endfunction

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			main_rate_r <= DPC_RST_MAIN_RATE;
			aux_bw_r <= DPC_RST_AUX_BW;
			main_locked_bw_r <= DPC_RST_MAIN_LOCKED_BW;
			main_acq_bw_r <= DPC_RST_MAIN_ACQ_BW;
			aux_damp_r <= DPC_RST_AUX_DAMP;
			main_damp_r <= DPC_RST_MAIN_DAMP;
			aux_gain_r <= DPC_RST_AUX_GAIN;
		end else if (clk_en && reg_wr) begin
			case (reg_addr)
				DPC_ADDR_MAIN_RATE: begin
					main_rate_r <= masked(reg_wdata, DPC_MSK_MAIN_RATE, DPC_RST_MAIN_RATE);
				end
				DPC_ADDR_AUX_BW: begin
					aux_bw_r <= masked(reg_wdata, DPC_MSK_AUX_BW, DPC_RST_AUX_BW);
				end
				DPC_ADDR_MAIN_LOCKED_BW: begin
					main_locked_bw_r <= masked(reg_wdata, DPC_MSK_MAIN_LOCKED_BW, DPC_RST_MAIN_LOCKED_BW);
				end
				DPC_ADDR_MAIN_ACQ_BW: begin
					main_acq_bw_r <= masked(reg_wdata, DPC_MSK_MAIN_ACQ_BW, DPC_RST_MAIN_ACQ_BW);
				end
				DPC_ADDR_AUX_DAMP: begin
					aux_damp_r <= masked(reg_wdata, DPC_MSK_DAMP, DPC_RST_AUX_DAMP);
				end
				DPC_ADDR_MAIN_DAMP: begin
					main_damp_r <= masked(reg_wdata, DPC_MSK_DAMP, DPC_RST_MAIN_DAMP);
				end
				DPC_ADDR_AUX_GAIN: begin
					aux_gain_r <= masked(reg_wdata, DPC_MSK_AUX_GAIN, DPC_RST_AUX_GAIN);
				end
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	always_comb begin
		rdata_nxt = 8'h00;
		hit_nxt = 1'b1;
		case (reg_addr)
			DPC_ADDR_MAIN_RATE: rdata_nxt = main_rate_r;
			DPC_ADDR_AUX_BW: rdata_nxt = aux_bw_r;
			DPC_ADDR_MAIN_LOCKED_BW: rdata_nxt = main_locked_bw_r;
			DPC_ADDR_MAIN_ACQ_BW: rdata_nxt = main_acq_bw_r;
			DPC_ADDR_AUX_DAMP: rdata_nxt = aux_damp_r;
			DPC_ADDR_MAIN_DAMP: rdata_nxt = main_damp_r;
			DPC_ADDR_AUX_GAIN: rdata_nxt = aux_gain_r;
			default: hit_nxt = 1'b0;
		endcase
	end

	// Data held until the next read so a slow serial shifter can pick it up
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
			reg_hit <= 1'b0;
		end else if (clk_en && reg_rd) begin
			reg_rdata <= rdata_nxt;
			reg_hit <= hit_nxt;
		end
	end

	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	function automatic dpc_bw_t aux_bw_dec(input logic [1:0] c);
		case (c)
			2'h0: aux_bw_dec = DPC_BW_18;
			2'h1: aux_bw_dec = DPC_BW_35;
			2'h2: aux_bw_dec = DPC_BW_70;
			default: aux_bw_dec = DPC_BW_NONE;
		endcase
	endfunction

	// Main loop bandwidth codes are rotated against the auxiliary ones
	function automatic dpc_bw_t main_bw_dec(input logic [3:0] c);
		case (c)
			4'h3: main_bw_dec = DPC_BW_18;
			4'h0: main_bw_dec = DPC_BW_35;
			4'h1: main_bw_dec = DPC_BW_70;
			default: main_bw_dec = DPC_BW_NONE;
		endcase
	endfunction

	function automatic logic [7:0] damp_dec(input dpc_bw_t bw, input logic [2:0] c);
		case (c)
			3'h1: damp_dec = DPC_DAMP_1P2;
			3'h2: damp_dec = DPC_DAMP_2P5;
			3'h3: damp_dec = DPC_DAMP_5;
			3'h4: damp_dec = (bw == DPC_BW_18) ? DPC_DAMP_5 : DPC_DAMP_10;
			3'h5: damp_dec = (bw == DPC_BW_18) ? DPC_DAMP_5 : ((bw == DPC_BW_35) ? DPC_DAMP_10 : DPC_DAMP_20);
			default: damp_dec = DPC_DAMP_NONE;
		endcase
	endfunction

	// ----------------------------------------
	// Configuration decode
	// ----------------------------------------
	logic [2:0] main_rate_code;
	logic [1:0] main_to_b_code;
	assign main_rate_code = main_rate_r[DPC_MAIN_RATE_LSB +: 3];
	assign main_to_b_code = main_rate_r[DPC_MAIN_TO_B_LSB +: 2];

	always_comb begin
		cfg_nxt = '0;
		cfg_nxt.main_rate_invalid = 1'b0;
		case (main_rate_code)
			3'h0: cfg_nxt.mult_a_rate = DPC_RATE_77M76;
			3'h1: begin
				cfg_nxt.mult_a_rate = DPC_RATE_77M76;
				cfg_nxt.mult_a_analog_fb = 1'b1;
			end
			3'h2: cfg_nxt.mult_a_rate = DPC_RATE_12E1;
			3'h3: cfg_nxt.mult_a_rate = DPC_RATE_16E1;
			3'h4: cfg_nxt.mult_a_rate = DPC_RATE_24DS1;
			3'h5: cfg_nxt.mult_a_rate = DPC_RATE_16DS1;
			default: begin
				// Forbidden codes silence the first multiplier rather than guess
				cfg_nxt.mult_a_rate = DPC_RATE_OFF;
				cfg_nxt.main_rate_invalid = 1'b1;
			end
		endcase
		cfg_nxt.mult_b_from_main = main_rate_r[DPC_MULT_B_SRC_BIT];
		if (main_rate_r[DPC_MULT_B_SRC_BIT]) begin
			case (main_to_b_code)
				2'h0: cfg_nxt.mult_b_main_rate = DPC_RATE_12E1;
				2'h1: cfg_nxt.mult_b_main_rate = DPC_RATE_16E1;
				2'h2: cfg_nxt.mult_b_main_rate = DPC_RATE_24DS1;
				default: cfg_nxt.mult_b_main_rate = DPC_RATE_OFF;
			endcase
		end
		cfg_nxt.aux_phase_measure = main_rate_r[DPC_PHASE_MEASURE_BIT];
		cfg_nxt.aux_enabled = !main_rate_r[DPC_PHASE_MEASURE_BIT];
		cfg_nxt.aux_bw = aux_bw_dec(aux_bw_r[1:0]);
		cfg_nxt.aux_damping_x10 = damp_dec(cfg_nxt.aux_bw, aux_damp_r[DPC_DAMP_LSB +: 3]);
		cfg_nxt.main_bw_active = main_phase_locked ? main_bw_dec({2'h0, main_locked_bw_r[1:0]})
			: main_bw_dec(main_acq_bw_r[3:0]);
		cfg_nxt.main_damping_x10 = damp_dec(cfg_nxt.main_bw_active, main_damp_r[DPC_DAMP_LSB +: 3]);
		cfg_nxt.aux_pd2_used = aux_gain_r[DPC_GAIN_EN_BIT];
		if (!aux_gain_r[DPC_GAIN_EN_BIT]) begin
			cfg_nxt.aux_pd2_gain = aux_gain_r[DPC_DIG_GAIN_LSB +: 3];
		end else begin
			case (aux_lock_mode)
				DPC_LOCK_ANALOG: cfg_nxt.aux_pd2_gain = aux_gain_r[DPC_HF_GAIN_LSB +: 3];
				DPC_LOCK_ANALOG_8K: cfg_nxt.aux_pd2_gain = aux_damp_r[DPC_LF_GAIN_LSB +: 3];
				default: cfg_nxt.aux_pd2_gain = aux_gain_r[DPC_DIG_GAIN_LSB +: 3];
			endcase
		end
		// Main low-frequency gain is zeroed when auto selection is off
		cfg_nxt.main_pd2_lowfreq_gain = main_auto_gain_en ? main_damp_r[DPC_LF_GAIN_LSB +: 3] : 3'h0;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_r <= '0;
		end else if (clk_en) begin
			cfg_r <= cfg_nxt;
		end
	end

	assign cfg = cfg_r;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence wr_main_rate_s(logic [7:0] d);
		clk_en && reg_wr && reg_addr == DPC_ADDR_MAIN_RATE && reg_wdata == d;
	endsequence

	// Write edge, then one enabled edge to load cfg, then cfg is visible
	sequence settle_s;
		clk_en ##1 1'b1;
	endsequence

	sequence rd_unmapped_s;
		clk_en && reg_rd && !hit_nxt;
	endsequence

	phase_measure_a: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && reg_wr && reg_addr == DPC_ADDR_MAIN_RATE ##1 clk_en
		|=> cfg.aux_enabled == !$past(reg_wdata[7], 2))
		else $error("aux loop enable does not follow phase-measure bit");

	mult_b_source_a: assert property (@(posedge clk) disable iff (!rst_n)
		wr_main_rate_s(8'h50) ##1 settle_s |-> cfg.mult_b_from_main && cfg.mult_b_main_rate == DPC_RATE_16E1)
		else $error("second multiplier source or rate wrong");

	rate_analog_fb_a: assert property (@(posedge clk) disable iff (!rst_n)
		wr_main_rate_s(8'h01) ##1 settle_s |-> cfg.mult_a_rate == DPC_RATE_77M76 && cfg.mult_a_analog_fb)
		else $error("rate code 001 not decoded as analog feedback");

	rate_forbidden_a: assert property (@(posedge clk) disable iff (!rst_n)
		cfg.main_rate_invalid |-> cfg.mult_a_rate == DPC_RATE_OFF && $past(main_rate_code[2:1], 1) == 2'h3)
		else $error("invalid flag without forbidden rate code");

	aux_bw_map_a: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && reg_wr && reg_addr == DPC_ADDR_AUX_BW && reg_wdata[1:0] == 2'h2 ##1 clk_en
		|=> cfg.aux_bw == DPC_BW_70)
		else $error("aux bandwidth code 10 not 70 Hz");

	main_bw_sel_a: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && main_phase_locked && main_locked_bw_r[1:0] == 2'h3 |=> cfg.main_bw_active == DPC_BW_18)
		else $error("locked bandwidth 11 not 18 Hz");

	acq_bw_sel_a: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && !main_phase_locked && main_acq_bw_r == 8'h10 |=> cfg.main_bw_active == DPC_BW_35)
		else $error("acquisition bandwidth 00 not 35 Hz");

	damping_dep_a: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && aux_damp_r[2:0] == 3'h5 && aux_bw_r[1:0] == 2'h2 |=> cfg.aux_damping_x10 == DPC_DAMP_20)
		else $error("damping 101 at 70 Hz not 20");

	gain_off_a: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && !aux_gain_r[7] |=> !cfg.aux_pd2_used && cfg.aux_pd2_gain == $past(aux_gain_r[2:0], 1))
		else $error("disabled auto gain must use digital gain and flag unused");

	gain_hf_a: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && aux_gain_r[7] && aux_lock_mode == DPC_LOCK_ANALOG |=> cfg.aux_pd2_gain == $past(aux_gain_r[6:4], 1))
		else $error("analog lock above 8 kHz not using high-frequency gain");

	unused_bits_a: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && reg_wr && reg_addr == DPC_ADDR_AUX_BW |=> aux_bw_r[7:2] == DPC_RST_AUX_BW[7:2])
		else $error("unused bits took a written value");

	rate_digital_fb_a: assert property (@(posedge clk) disable iff (!rst_n)
		wr_main_rate_s(8'h00) ##1 settle_s |-> cfg.mult_a_rate == DPC_RATE_77M76 && !cfg.mult_a_analog_fb)
		else $error("rate code 000 not decoded as digital feedback");

	mult_b_off_a: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && !main_rate_r[DPC_MULT_B_SRC_BIT] |=> !cfg.mult_b_from_main && cfg.mult_b_main_rate == DPC_RATE_OFF)
		else $error("second multiplier not fed from auxiliary loop");

	gain_lf_a: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && aux_gain_r[7] && aux_lock_mode == DPC_LOCK_ANALOG_8K |=> cfg.aux_pd2_gain == $past(aux_damp_r[6:4], 1))
		else $error("analog lock at 8 kHz not using low-frequency gain");

	gain_digital_a: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && aux_gain_r[7] && aux_lock_mode == DPC_LOCK_DIGITAL |=> cfg.aux_pd2_gain == $past(aux_gain_r[2:0], 1))
		else $error("digital lock not using digital gain");

	main_lf_off_a: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && !main_auto_gain_en |=> cfg.main_pd2_lowfreq_gain == 3'h0)
		else $error("main low-frequency gain applied without auto selection");

	read_unmapped_a: assert property (@(posedge clk) disable iff (!rst_n)
		rd_unmapped_s |=> !reg_hit && reg_rdata == 8'h00)
		else $error("unmapped read did not return zero without hit");
endmodule
`default_nettype wire

// *** logic/dpc_pkg.sv ***
// Package: register map, field layout and decoded types for the loop configuration block
`default_nettype none
package dpc_pkg;
	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] DPC_ADDR_MAIN_RATE = 8'h65;
	localparam logic [7:0] DPC_ADDR_AUX_BW = 8'h66;
	localparam logic [7:0] DPC_ADDR_MAIN_LOCKED_BW = 8'h67;
	localparam logic [7:0] DPC_ADDR_MAIN_ACQ_BW = 8'h69;
	localparam logic [7:0] DPC_ADDR_AUX_DAMP = 8'h6a;
	localparam logic [7:0] DPC_ADDR_MAIN_DAMP = 8'h6b;
	localparam logic [7:0] DPC_ADDR_AUX_GAIN = 8'h6c;
	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] DPC_RST_MAIN_RATE = 8'h01;
	localparam logic [7:0] DPC_RST_AUX_BW = 8'h00;
	localparam logic [7:0] DPC_RST_MAIN_LOCKED_BW = 8'h10;
	localparam logic [7:0] DPC_RST_MAIN_ACQ_BW = 8'h11;
	localparam logic [7:0] DPC_RST_AUX_DAMP = 8'h13;
	localparam logic [7:0] DPC_RST_MAIN_DAMP = 8'h13;
	localparam logic [7:0] DPC_RST_AUX_GAIN = 8'hc2;
	// ----------------------------------------
	// Writable bit masks
	// ----------------------------------------
	localparam logic [7:0] DPC_MSK_MAIN_RATE = 8'hf7;
	localparam logic [7:0] DPC_MSK_AUX_BW = 8'h03;
	localparam logic [7:0] DPC_MSK_MAIN_LOCKED_BW = 8'h03;
	localparam logic [7:0] DPC_MSK_MAIN_ACQ_BW = 8'h0f;
	localparam logic [7:0] DPC_MSK_DAMP = 8'h77;
	localparam logic [7:0] DPC_MSK_AUX_GAIN = 8'hf7;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int DPC_PHASE_MEASURE_BIT = 7;
	localparam int DPC_MULT_B_SRC_BIT = 6;
	localparam int DPC_MAIN_TO_B_LSB = 4;
	localparam int DPC_MAIN_RATE_LSB = 0;
	localparam int DPC_GAIN_EN_BIT = 7;
	localparam int DPC_HF_GAIN_LSB = 4;
	localparam int DPC_LF_GAIN_LSB = 4;
	localparam int DPC_DAMP_LSB = 0;
	localparam int DPC_DIG_GAIN_LSB = 0;
	// ----------------------------------------
	// Damping factors, times ten
	// ----------------------------------------
	localparam logic [7:0] DPC_DAMP_1P2 = 8'h0c;
	localparam logic [7:0] DPC_DAMP_2P5 = 8'h19;
	localparam logic [7:0] DPC_DAMP_5 = 8'h32;
	localparam logic [7:0] DPC_DAMP_10 = 8'h64;
	localparam logic [7:0] DPC_DAMP_20 = 8'hc8;
	localparam logic [7:0] DPC_DAMP_NONE = 8'h00;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		DPC_BW_NONE = 2'h0,
		DPC_BW_18 = 2'h1,
		DPC_BW_35 = 2'h2,
		DPC_BW_70 = 2'h3
	} dpc_bw_t;
	typedef enum logic [2:0] {
		DPC_RATE_OFF = 3'h0,
		DPC_RATE_77M76 = 3'h1,
		DPC_RATE_12E1 = 3'h2,
		DPC_RATE_16E1 = 3'h3,
		DPC_RATE_24DS1 = 3'h4,
		DPC_RATE_16DS1 = 3'h5
	} dpc_rate_t;
	typedef enum logic [1:0] {
		DPC_LOCK_DIGITAL = 2'h0,
		DPC_LOCK_ANALOG = 2'h1,
		DPC_LOCK_ANALOG_8K = 2'h2
	} dpc_lock_t;
	typedef struct packed {
		dpc_rate_t mult_a_rate;
		logic mult_a_analog_fb;
		logic main_rate_invalid;
		logic mult_b_from_main;
		dpc_rate_t mult_b_main_rate;
		logic aux_enabled;
		logic aux_phase_measure;
		dpc_bw_t aux_bw;
		logic [7:0] aux_damping_x10;
		dpc_bw_t main_bw_active;
		logic [7:0] main_damping_x10;
		logic aux_pd2_used;
		logic [2:0] aux_pd2_gain;
		logic [2:0] main_pd2_lowfreq_gain;
	} dpc_cfg_t;
endpackage
`default_nettype wire

// *** tb/dpc_loop_config_tb.sv ***
// Self-checking testbench for the loop configuration register block
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	import dpc_pkg::*;
	// ----------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic clk_en = 1'b1;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic reg_hit;
	logic main_phase_locked = 1'b0;
	dpc_lock_t aux_lock_mode = DPC_LOCK_DIGITAL;
	logic main_auto_gain_en = 1'b0;
	dpc_cfg_t cfg;
	int num_errors = 0;
	int n_compared = 0;
	logic [8:0] exp_q[$];
	logic rd_seen;
	logic [31:0] seed = 32'd88742;
	logic [7:0] addrs [7] = '{DPC_ADDR_MAIN_RATE, DPC_ADDR_AUX_BW, DPC_ADDR_MAIN_LOCKED_BW, DPC_ADDR_MAIN_ACQ_BW,
		DPC_ADDR_AUX_DAMP, DPC_ADDR_MAIN_DAMP, DPC_ADDR_AUX_GAIN};
	logic [7:0] rsts [7] = '{DPC_RST_MAIN_RATE, DPC_RST_AUX_BW, DPC_RST_MAIN_LOCKED_BW, DPC_RST_MAIN_ACQ_BW,
		DPC_RST_AUX_DAMP, DPC_RST_MAIN_DAMP, DPC_RST_AUX_GAIN};
	logic [7:0] msks [7] = '{DPC_MSK_MAIN_RATE, DPC_MSK_AUX_BW, DPC_MSK_MAIN_LOCKED_BW, DPC_MSK_MAIN_ACQ_BW,
		DPC_MSK_DAMP, DPC_MSK_DAMP, DPC_MSK_AUX_GAIN};
	logic [7:0] v, hf, lf, dg, mlf, g;
	logic [8:0] e;
	dpc_bw_t bw;

	always #12.5 clk = ~clk;

	dpc_loop_config dut_u (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
		.main_phase_locked(main_phase_locked), .aux_lock_mode(aux_lock_mode),
		.main_auto_gain_en(main_auto_gain_en), .cfg(cfg));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [7:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction

	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask

	// Expectation is queued when the strobe goes out, the monitor pops it
	task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic hit);
		@(negedge clk);
		reg_rd = 1'b1;
		reg_addr = a;
		exp_q.push_back({hit, d});
		@(negedge clk);
		reg_rd = 1'b0;
	endtask

	function automatic dpc_bw_t aux_bw_of(input logic [1:0] c);
		case (c)
			2'h0: return DPC_BW_18;
			2'h1: return DPC_BW_35;
			2'h2: return DPC_BW_70;
			default: return DPC_BW_NONE;
		endcase
	endfunction

	function automatic dpc_bw_t main_bw_of(input logic [3:0] c);
		case (c)
			4'h3: return DPC_BW_18;
			4'h0: return DPC_BW_35;
			4'h1: return DPC_BW_70;
			default: return DPC_BW_NONE;
		endcase
	endfunction

	function automatic logic [7:0] damp_of(input logic [2:0] c, input dpc_bw_t b);
		case (c)
			3'h1: return DPC_DAMP_1P2;
			3'h2: return DPC_DAMP_2P5;
			3'h3: return DPC_DAMP_5;
			3'h4: return (b == DPC_BW_18) ? DPC_DAMP_5 : DPC_DAMP_10;
			3'h5: return (b == DPC_BW_18) ? DPC_DAMP_5 : ((b == DPC_BW_35) ? DPC_DAMP_10 : DPC_DAMP_20);
			default: return DPC_DAMP_NONE;
		endcase
	endfunction

	function automatic logic [7:0] rate_a_of(input logic [2:0] c);
		case (c)
			3'h0, 3'h1: return {5'h00, DPC_RATE_77M76};
			3'h2: return {5'h00, DPC_RATE_12E1};
			3'h3: return {5'h00, DPC_RATE_16E1};
			3'h4: return {5'h00, DPC_RATE_24DS1};
			3'h5: return {5'h00, DPC_RATE_16DS1};
			default: return {5'h00, DPC_RATE_OFF};
		endcase
	endfunction

	function automatic logic [7:0] rate_b_of(input logic sel, input logic [1:0] c);
		if (!sel) return {5'h00, DPC_RATE_OFF};
		case (c)
			2'h0: return {5'h00, DPC_RATE_12E1};
			2'h1: return {5'h00, DPC_RATE_16E1};
			2'h2: return {5'h00, DPC_RATE_24DS1};
			default: return {5'h00, DPC_RATE_OFF};
		endcase
	endfunction
	// ----------------------------------------
	// Read-result monitor
	// ----------------------------------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) rd_seen <= 1'b0;
		else rd_seen <= reg_rd && clk_en;
	end

	always @(negedge clk) begin
		if (rd_seen) begin
			if (exp_q.size() == 0) check(8'h01, 8'h00, "unexpected read result");
			else begin
				e = exp_q.pop_front();
				check(reg_rdata, e[7:0], "read data");
				check({7'h00, reg_hit}, {7'h00, e[8]}, "read hit");
			end
		end
	end
	// ----------------------------------------
	// Closing and watchdog
	// ----------------------------------------
	task automatic end_of_test();
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	// Whole run is about 670 cycles; nine times that means a hang
	initial begin
		#(25ns * 6000);
		num_errors++;
		end_of_test();
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (6) @(posedge clk);
		@(negedge clk) rst_n = 1'b1;
		for (int i = 0; i < 7; i++) rd(addrs[i], rsts[i], 1'b1);
		wr(8'h68, 8'hff);
		rd(8'h68, 8'h00, 1'b0);
		rd(8'h6d, 8'h00, 1'b0);
		for (int i = 0; i < 7; i++) begin
			wr(addrs[i], 8'hff);
			rd(addrs[i], msks[i] | (rsts[i] & ~msks[i]), 1'b1);
			wr(addrs[i], 8'h00);
			rd(addrs[i], rsts[i] & ~msks[i], 1'b1);
		end
		// Rate and routing codes, upper bits random; two fixed routing cases last
		for (int c = 0; c < 10; c++) begin
			v = (c == 8) ? 8'h50 : ((c == 9) ? 8'h01 : ({rnd() & 8'hf8} | 8'(c)));
			wr(DPC_ADDR_MAIN_RATE, v);
			@(negedge clk);
			check({5'h00, cfg.mult_a_rate}, rate_a_of(v[2:0]), "rate a");
			check({7'h00, cfg.mult_a_analog_fb}, {7'h00, v[2:0] == 3'h1}, "analog fb");
			check({7'h00, cfg.main_rate_invalid}, {7'h00, v[2:1] == 2'h3}, "invalid");
			check({7'h00, cfg.mult_b_from_main}, {7'h00, v[6]}, "b source");
			check({5'h00, cfg.mult_b_main_rate}, rate_b_of(v[6], v[5:4]), "rate b");
			check({6'h00, cfg.aux_phase_measure, cfg.aux_enabled}, {6'h00, v[7], !v[7]}, "measure");
		end
		// Auxiliary bandwidth against every damping code
		for (int b = 0; b < 4; b++) begin
			for (int d = 0; d < 8; d++) begin
				wr(DPC_ADDR_AUX_BW, 8'(b) | (rnd() & 8'hfc));
				wr(DPC_ADDR_AUX_DAMP, 8'(d));
				@(negedge clk);
				check({6'h00, cfg.aux_bw}, {6'h00, aux_bw_of(2'(b))}, "aux bw");
				if (b != 3) check(cfg.aux_damping_x10, damp_of(3'(d), aux_bw_of(2'(b))), "aux damp");
			end
		end
		// Locked versus acquisition bandwidth, main damping
		for (int lk = 0; lk < 2; lk++) begin
			for (int b = 0; b < 5; b++) begin
				wr(DPC_ADDR_MAIN_LOCKED_BW, 8'(b & 3));
				wr(DPC_ADDR_MAIN_ACQ_BW, (b == 4) ? 8'h07 : 8'((b & 3) ^ 1));
				main_phase_locked = lk[0];
				bw = lk[0] ? main_bw_of(4'(b & 3)) : main_bw_of((b == 4) ? 4'h7 : 4'((b & 3) ^ 1));
				for (int d = 0; d < 8; d++) begin
					wr(DPC_ADDR_MAIN_DAMP, 8'(d));
					@(negedge clk);
					check({6'h00, cfg.main_bw_active}, {6'h00, bw}, "main bw");
					if (bw != DPC_BW_NONE) check(cfg.main_damping_x10, damp_of(3'(d), bw), "main damp");
				end
			end
		end
		// Second detector gain selection
		for (int k = 0; k < 16; k++) begin
			hf = rnd() & 8'h07;
			lf = rnd() & 8'h07;
			dg = rnd() & 8'h07;
			mlf = rnd() & 8'h07;
			wr(DPC_ADDR_AUX_GAIN, {k[0], hf[2:0], 1'b0, dg[2:0]});
			wr(DPC_ADDR_AUX_DAMP, {1'b0, lf[2:0], 4'h1});
			wr(DPC_ADDR_MAIN_DAMP, {1'b0, mlf[2:0], 4'h1});
			aux_lock_mode = dpc_lock_t'(k[2:1]);
			main_auto_gain_en = k[3];
			@(negedge clk);
			g = !k[0] ? dg : ((k[2:1] == 2'h1) ? hf : ((k[2:1] == 2'h2) ? lf : dg));
			check({7'h00, cfg.aux_pd2_used}, {7'h00, k[0]}, "pd2 used");
			check({5'h00, cfg.aux_pd2_gain}, g, "aux gain");
			check({5'h00, cfg.main_pd2_lowfreq_gain}, k[3] ? mlf : 8'h00, "main lf gain");
		end
		// Frozen clock enable takes no write
		clk_en = 1'b0;
		wr(DPC_ADDR_AUX_BW, 8'h02);
		clk_en = 1'b1;
		rd(DPC_ADDR_AUX_BW, 8'h03, 1'b1);
		repeat (3) @(negedge clk);
		end_of_test();
	end
endmodule
`default_nettype wire
